// ==== dv/tcu_tb.sv ====
// self-checking bench for the nibble-register timer
`timescale 1ns/1ps
`default_nettype none
`include "tcu_map.svh"

module testbench
    import tcu_pkg::*;
;
    logic        i_clk, i_resetn, i_stop_enter, i_port_out, i_port_oe;
    logic [11:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata, o_rdata, rd;
    logic [3:0]  i_wstrb;
    logic        i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0]  o_bresp, o_rresp, rs;
    logic        o_pin_out, o_pin_oe, o_ovf_irq, o_wdt_reset;
    int          failures, samples_checked;
    int          taps [8] = '{2048, 1024, 512, 128, 32, 8, 4, 2};

    tcu_timer #(.AW(12)) uut (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_stop_enter(i_stop_enter),
        .i_port_out(i_port_out), .i_port_oe(i_port_oe),
        .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
        .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
        .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
        .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
        .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
        .o_rvalid(o_rvalid), .i_rready(i_rready), .o_pin_out(o_pin_out),
        .o_pin_oe(o_pin_oe), .o_ovf_irq(o_ovf_irq),
        .o_wdt_reset(o_wdt_reset));

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // ready is stable from the falling edge, so sampling there is race free
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic ta, tw, tb;
        int   n;
        n = 0;
        @(posedge i_clk);
        i_awaddr  <= {2'b00, idx, 2'b00};
        i_wdata   <= d;
        i_awvalid <= 1'b1;
        i_wvalid  <= 1'b1;
        i_bready  <= 1'b1;
        do begin
            @(negedge i_clk);
            ta = i_awvalid & o_awready;
            tw = i_wvalid & o_wready;
            tb = o_bvalid;
            rs = o_bresp;
            @(posedge i_clk);
            if (ta) i_awvalid <= 1'b0;
            if (tw) i_wvalid <= 1'b0;
            n++;
        end while (tb !== 1'b1 && n < 100);
        i_bready <= 1'b0;
        if (n >= 100) failures++;
    endtask : wr

    task automatic rdr(input logic [7:0] idx);
        logic ta, tb;
        int   n;
        n = 0;
        @(posedge i_clk);
        i_araddr  <= {2'b00, idx, 2'b00};
        i_arvalid <= 1'b1;
        i_rready  <= 1'b1;
        do begin
            @(negedge i_clk);
            ta = i_arvalid & o_arready;
            tb = o_rvalid;
            rd = o_rdata;
            rs = o_rresp;
            @(posedge i_clk);
            if (ta) i_arvalid <= 1'b0;
            n++;
        end while (tb !== 1'b1 && n < 100);
        i_rready <= 1'b0;
        if (n >= 100) failures++;
    endtask : rdr

    task automatic rchk(input string what, input logic [7:0] idx,
                        input logic [31:0] exp);
        rdr(idx);
        chk(what, exp, rd);
    endtask : rchk

    task automatic wait_irq();
        int n;
        n = 0;
        while (o_ovf_irq !== 1'b1 && n < 300) begin
            @(negedge i_clk);
            n++;
        end
    endtask : wait_irq

    task automatic toggle(output int n);
        logic p;
        p = o_pin_out;
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (o_pin_out === p && n < 40000);
    endtask : toggle

    task automatic t_reset();
        rchk("ctrl", `TCU_IDX_CTRL, 32'h0000_0001);
        rchk("status", `TCU_IDX_STATUS, 32'h0000_0000);
        rchk("watchdog_enable_flag", `TCU_IDX_WATCHDOG_ENABLE_FLAG, 32'h0000_0000);
        rchk("count", `TCU_IDX_COUNT, 32'h0000_0000);
        @(negedge i_clk);
        chk("pin out", 32'h0000_0001, {31'h0, o_pin_out});
        chk("pin oe", 32'h0000_0000, {31'h0, o_pin_oe});
        // port logic must reach the pin in both levels
        @(posedge i_clk);
        i_port_out <= 1'b0;
        i_port_oe  <= 1'b1;
        @(negedge i_clk);
        chk("pin out", 32'h0000_0000, {31'h0, o_pin_out});
        chk("pin oe", 32'h0000_0001, {31'h0, o_pin_oe});
        @(posedge i_clk);
        i_port_out <= 1'b1;
        i_port_oe  <= 1'b0;
        rchk("unmapped", 8'h30, 32'h0000_0000);
        chk("unmapped resp", {30'h0, `TCU_RESP_SLVERR}, {30'h0, rs});
        wr(8'h30, 32'h0000_0001);
        chk("unmapped wr resp", {30'h0, `TCU_RESP_SLVERR}, {30'h0, rs});
        $display("reset test done");
    endtask : t_reset

    task automatic t_nibble();
        wr(`TCU_IDX_LOW_NIB, 32'h0000_0005);
        rchk("count", `TCU_IDX_COUNT, 32'h0000_0000);
        wr(`TCU_IDX_HIGH_NIB, 32'h0000_000a);
        rchk("count", `TCU_IDX_COUNT, 32'h0000_00a5);
        // a write without lane 0 must not load the counter
        i_wstrb <= 4'h0;
        wr(`TCU_IDX_HIGH_NIB, 32'h0000_0006);
        i_wstrb <= 4'hf;
        rchk("count", `TCU_IDX_COUNT, 32'h0000_00a5);
        wr(`TCU_IDX_HIGH_NIB, 32'h0000_0003);
        rchk("count", `TCU_IDX_COUNT, 32'h0000_0035);
        rchk("high read", `TCU_IDX_HIGH_NIB, 32'h0000_0003);
        wr(`TCU_IDX_LOW_NIB, 32'h0000_0009);
        wr(`TCU_IDX_HIGH_NIB, 32'h0000_0007);
        rchk("low read", `TCU_IDX_LOW_NIB, 32'h0000_0005);
        rchk("high read", `TCU_IDX_HIGH_NIB, 32'h0000_0007);
        rchk("low read", `TCU_IDX_LOW_NIB, 32'h0000_0009);
        $display("nibble test done");
    endtask : t_nibble

    task automatic t_overflow();
        wr(`TCU_IDX_CTRL, 32'h0000_0000);
        wr(`TCU_IDX_TIMER_MODE, 32'h0000_0007);
        wr(`TCU_IDX_LOW_NIB, 32'h0000_000e);
        wr(`TCU_IDX_HIGH_NIB, 32'h0000_000f);
        wait_irq();
        chk("irq", 32'h0000_0001, {31'h0, o_ovf_irq});
        rchk("count", `TCU_IDX_COUNT, 32'h0000_0000);
        wr(`TCU_IDX_STATUS, 32'h0000_0000);
        @(negedge i_clk);
        chk("irq", 32'h0000_0000, {31'h0, o_ovf_irq});
        wr(`TCU_IDX_TIMER_MODE, 32'h0000_000f);
        wr(`TCU_IDX_LOW_NIB, 32'h0000_0000);
        wr(`TCU_IDX_HIGH_NIB, 32'h0000_000f);
        wait_irq();
        rchk("count", `TCU_IDX_COUNT, 32'h0000_00f0);
        wr(`TCU_IDX_CTRL, 32'h0000_0001);
        @(negedge i_clk);
        chk("irq", 32'h0000_0000, {31'h0, o_ovf_irq});
        rchk("status", `TCU_IDX_STATUS, 32'h0000_0001);
        wr(`TCU_IDX_STATUS, 32'h0000_0000);
        $display("overflow test done");
    endtask : t_overflow

    // overflow period seen as the distance between two pin toggles
    task automatic t_period();
        int sel [5] = '{7, 6, 5, 7, 7};
        int div [5] = '{0, 0, 0, 1, 3};
        int n;
        int want;
        wr(`TCU_IDX_PORT_MODE, 32'h0000_0004);
        @(negedge i_clk);
        chk("pin oe", 32'h0000_0001, {31'h0, o_pin_oe});
        for (int k = 0; k < 5; k++) begin
            wr(`TCU_IDX_CTRL, 32'((div[k] << 1) | 1));
            wr(`TCU_IDX_TIMER_MODE, 32'(sel[k]));
            wr(`TCU_IDX_LOW_NIB, 32'h0000_0000);
            wr(`TCU_IDX_HIGH_NIB, 32'h0000_000f);
            toggle(n);
            toggle(n);
            want = 256 * taps[sel[k]] * (4 << div[k]);
            chk("period", want, n);
        end
        $display("period test done");
    endtask : t_period

    task automatic t_watchdog();
        int n;
        wr(`TCU_IDX_WATCHDOG_ENABLE_FLAG, 32'h0000_0001);
        wr(`TCU_IDX_WATCHDOG_ENABLE_FLAG, 32'h0000_0000);
        rchk("watchdog_enable_flag", `TCU_IDX_WATCHDOG_ENABLE_FLAG, 32'h0000_0001);
        wr(`TCU_IDX_TIMER_MODE, 32'h0000_0007);
        wr(`TCU_IDX_LOW_NIB, 32'h0000_000e);
        wr(`TCU_IDX_HIGH_NIB, 32'h0000_000f);
        n = 0;
        while (o_wdt_reset !== 1'b1 && n < 300) begin
            @(negedge i_clk);
            n++;
        end
        chk("wdt", 32'h0000_0001, {31'h0, o_wdt_reset});
        @(negedge i_clk);
        chk("wdt", 32'h0000_0000, {31'h0, o_wdt_reset});
        @(posedge i_clk);
        i_stop_enter <= 1'b1;
        @(posedge i_clk);
        i_stop_enter <= 1'b0;
        rchk("watchdog_enable_flag", `TCU_IDX_WATCHDOG_ENABLE_FLAG, 32'h0000_0000);
        rchk("count", `TCU_IDX_COUNT, 32'h0000_0000);
        wr(`TCU_IDX_HIGH_NIB, 32'h0000_0003);
        rchk("count", `TCU_IDX_COUNT, 32'h0000_0030);
        // a surviving fast select ticks every 64 clocks; wait past that
        repeat (100) @(posedge i_clk);
        rchk("count", `TCU_IDX_COUNT, 32'h0000_0030);
        $display("watchdog test done");
    endtask : t_watchdog

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    initial begin
        // tests need about 37000 clocks; keep the run under 80000
        repeat (80000) @(posedge i_clk);
        failures++;
        wrap_up();
    end

    initial begin
        failures = 0;
        samples_checked = 0;
        {i_resetn, i_stop_enter, i_port_oe} = 3'b000;
        i_port_out = 1'b1;
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
        i_awaddr = 12'h000;
        i_araddr = 12'h000;
        i_wdata = 32'h0000_0000;
        i_wstrb = 4'hf;
        repeat (20) @(posedge i_clk);
        i_resetn <= 1'b1;
        t_reset();
        t_nibble();
        t_overflow();
        t_period();
        t_watchdog();
        wrap_up();
    end
endmodule : testbench

`default_nettype wire

// ==== inc/tcu_map.svh ====
// register map, field positions, reset values and counts of the timer
`ifndef TCU_MAP_SVH
`define TCU_MAP_SVH

`define TCU_IDX_PORT_MODE  8'h04
`define TCU_IDX_TIMER_MODE 8'h0d
`define TCU_IDX_LOW_NIB    8'h0e
`define TCU_IDX_HIGH_NIB   8'h0f
`define TCU_IDX_WATCHDOG_ENABLE_FLAG       8'h20
`define TCU_IDX_CTRL       8'h21
`define TCU_IDX_STATUS     8'h22
`define TCU_IDX_COUNT      8'h23
`define TCU_IDX_TOP        10

`define TCU_FSEL_BIT       3
`define TCU_CSEL_MSB       2
`define TCU_PINF_BIT       2
`define TCU_MASK_BIT       0
`define TCU_DIV_LSB        1
`define TCU_DIV_MSB        2
`define TCU_FLAG_BIT       0
`define TCU_WATCHDOG_ENABLE_FLAG_BIT       0

`define TCU_MODE_RST       4'h0
`define TCU_NIB_RST        4'h0
`define TCU_CNT_RST        8'h00
`define TCU_CNT_MAX        8'hff
`define TCU_CNT_ONE        8'h01
`define TCU_MASK_RST       1'b1
`define TCU_DIV_RST        2'h0

`define TCU_RESP_OKAY      2'h0
`define TCU_RESP_SLVERR    2'h2

`define TCU_PSC_W          16
`define TCU_INSTR_LOG2     5'h02
`define TCU_TAP0_LOG2      5'h0b
`define TCU_TAP1_LOG2      5'h0a
`define TCU_TAP2_LOG2      5'h09
`define TCU_TAP3_LOG2      5'h07
`define TCU_TAP4_LOG2      5'h05
`define TCU_TAP5_LOG2      5'h03
`define TCU_TAP6_LOG2      5'h02
`define TCU_TAP7_LOG2      5'h01

`endif

// ==== inc/tcu_pkg.sv ====
// state types of the timer and its prescaler
`default_nettype none
`include "tcu_map.svh"

package tcu_pkg;

    typedef struct packed {
        logic [`TCU_PSC_W-1:0] cnt;
        logic                  tick;
    } tcu_psc_t;

    typedef struct packed {
        logic       aw_hold;
        logic [7:0] aw_idx;
        logic       aw_hit;
        logic       w_hold;
        logic [3:0] w_nib;
        logic       w_lane;
        logic       bvalid;
        logic [1:0] bresp;
        logic       rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic [3:0] timer_mode;
        logic [3:0] port_mode;
        logic [3:0] wr_low;
        logic [3:0] wr_high;
        logic [3:0] rd_low;
        logic [7:0] cnt;
        logic       watchdog_enable_flag;
        logic       ovf_flag;
        logic       irq_mask;
        logic [1:0] sys_div;
        logic       tout;
        logic       wdt_rst;
    } tcu_state_t;

endpackage : tcu_pkg
`default_nettype wire

// ==== rtl/tcu_prescaler.sv ====
// prescaler producing one-cycle ticks at the selected tap
`timescale 1ns/1ps
`default_nettype none
`include "tcu_map.svh"

module tcu_prescaler
    import tcu_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_clear,
    input  wire logic [2:0] i_clk_sel,
    input  wire logic [1:0] i_sys_div,
    output logic            o_tick
);

    tcu_psc_t s_q;
    tcu_psc_t s_d;

    function automatic logic [4:0] tap_log2(input logic [2:0] sel);
        case (sel)
            3'h0: tap_log2 = `TCU_TAP0_LOG2;
            3'h1: tap_log2 = `TCU_TAP1_LOG2;
            3'h2: tap_log2 = `TCU_TAP2_LOG2;
            3'h3: tap_log2 = `TCU_TAP3_LOG2;
            3'h4: tap_log2 = `TCU_TAP4_LOG2;
            3'h5: tap_log2 = `TCU_TAP5_LOG2;
            3'h6: tap_log2 = `TCU_TAP6_LOG2;
            default: tap_log2 = `TCU_TAP7_LOG2;
        endcase
    endfunction : tap_log2

    logic [4:0]            span;
    logic [`TCU_PSC_W-1:0] mask;

    always_comb begin
        // oscillator periods per tick: tap * (4 << divisor)
        span = tap_log2(i_clk_sel) + `TCU_INSTR_LOG2 + {3'h0, i_sys_div};
        mask = ~({`TCU_PSC_W{1'b1}} << span);
        s_d = s_q;
        s_d.cnt = i_clear ? '0 : s_q.cnt + 1'b1;
        // one pulse per wrap of the low bits, never two in a row
        s_d.tick = !i_clear && ((s_q.cnt & mask) == mask);
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_tick = s_q.tick;

endmodule : tcu_prescaler
`default_nettype wire

// ==== rtl/tcu_timer.sv ====
// 8-bit timer with nibble registers over an AXI4-Lite slave
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tcu_map.svh"

// Behaviour
// - 4-bit write-only mode register, zero on reset and stop entry.
// - function bit 0 selects free-running, 1 selects reload.
// - clock select picks 2048..2 instruction cycles per tick.
// - instruction cycle is 4, 8, 16 or 32 oscillator periods.
// - pin function bit routes shared pin: 0 port, 1 timer output.
// - 8-bit counter increments once per selected tick.
// - overflow sets the overflow request flag.
// - free-running overflow returns the counter to zero.
// - reload overflow loads the counter from the write pair.
// - counter is zero after reset and stop entry.
// - low nibble write stores only, counter untouched.
// - high nibble write loads counter from both nibbles at once.
// - later high-only writes reuse the stored low nibble.
// - low write nibble cleared on reset and stop entry.
// - high read returns live upper bits and latches lower bits.
// - low read returns the latched lower bits.
// - read registers hold no defined value after reset or stop.
// - watchdog flag can be set by software, never cleared.
// - overflow with watchdog flag set forces system reset.
// - watchdog flag cleared on reset and stop entry.
// - overflow interrupts only while mask is 0; flag cleared by software.
module tcu_timer
    import tcu_pkg::*;
#(
    parameter int AW = 12
) (
    input  wire logic          i_clk,
    input  wire logic          i_resetn,
    input  wire logic          i_stop_enter,
    input  wire logic          i_port_out,
    input  wire logic          i_port_oe,
    input  wire logic [AW-1:0] i_awaddr,
    input  wire logic          i_awvalid,
    output logic               o_awready,
    input  wire logic [31:0]   i_wdata,
    input  wire logic [3:0]    i_wstrb,
    input  wire logic          i_wvalid,
    output logic               o_wready,
    output logic [1:0]         o_bresp,
    output logic               o_bvalid,
    input  wire logic          i_bready,
    input  wire logic [AW-1:0] i_araddr,
    input  wire logic          i_arvalid,
    output logic               o_arready,
    output logic [31:0]        o_rdata,
    output logic [1:0]         o_rresp,
    output logic               o_rvalid,
    input  wire logic          i_rready,
    output logic               o_pin_out,
    output logic               o_pin_oe,
    output logic               o_ovf_irq,
    output logic               o_wdt_reset
);

    tcu_state_t s_q;
    tcu_state_t s_d;
    logic       tick;

    // one decode for both address channels
    function automatic logic [8:0] decode(input logic [AW-1:0] a);
        logic [7:0] idx;
        logic       ok;
        idx = a[9:2];
        ok = (a[1:0] == 2'h0) && ((a >> `TCU_IDX_TOP) == '0);
        if (ok) begin
            case (idx)
                `TCU_IDX_PORT_MODE,
                `TCU_IDX_TIMER_MODE,
                `TCU_IDX_LOW_NIB,
                `TCU_IDX_HIGH_NIB,
                `TCU_IDX_WATCHDOG_ENABLE_FLAG,
                `TCU_IDX_CTRL,
                `TCU_IDX_STATUS,
                `TCU_IDX_COUNT: ok = 1'b1;
                default: ok = 1'b0;
            endcase
        end
        decode = {ok, idx};
    endfunction : decode

    tcu_prescaler u_psc (
        .i_clk     (i_clk),
        .i_resetn  (i_resetn),
        .i_clear   (i_stop_enter),
        .i_clk_sel (s_q.timer_mode[`TCU_CSEL_MSB:0]),
        .i_sys_div (s_q.sys_div),
        .o_tick    (tick)
    );

    logic       wr_go;
    logic       wr_lo;
    logic       wr_hi;
    logic       ar_go;
    logic       rd_hi;
    logic       ovf;
    logic [8:0] ar_dec;
    logic [8:0] aw_dec;
    logic [7:0] rd_val;

    assign aw_dec = decode(i_awaddr);
    assign ar_dec = decode(i_araddr);
    assign o_awready = !s_q.aw_hold && !s_q.bvalid;
    assign o_wready = !s_q.w_hold && !s_q.bvalid;
    assign o_arready = !s_q.rvalid;

    always_comb begin
        wr_go = s_q.aw_hold && s_q.w_hold && !s_q.bvalid;
        wr_lo = wr_go && s_q.w_lane && s_q.aw_hit
            && (s_q.aw_idx == `TCU_IDX_LOW_NIB);
        wr_hi = wr_go && s_q.w_lane && s_q.aw_hit
            && (s_q.aw_idx == `TCU_IDX_HIGH_NIB);
        ar_go = i_arvalid && !s_q.rvalid;
        rd_hi = ar_go && ar_dec[8] && (ar_dec[7:0] == `TCU_IDX_HIGH_NIB);
        // a high-nibble load in the same cycle beats the tick
        ovf = tick && (s_q.cnt == `TCU_CNT_MAX)
            && !wr_hi && !i_stop_enter;

        case (ar_dec[7:0])
            `TCU_IDX_LOW_NIB: rd_val = {4'h0, s_q.rd_low};
            `TCU_IDX_HIGH_NIB: rd_val = {4'h0, s_q.cnt[7:4]};
            `TCU_IDX_WATCHDOG_ENABLE_FLAG: rd_val = {7'h00, s_q.watchdog_enable_flag};
            `TCU_IDX_CTRL: rd_val = {5'h00, s_q.sys_div, s_q.irq_mask};
            `TCU_IDX_STATUS: rd_val = {7'h00, s_q.ovf_flag};
            `TCU_IDX_COUNT: rd_val = s_q.cnt;
            // mode registers are write-only and read as zero
            default: rd_val = 8'h00;
        endcase
        // refused addresses read as zero, even misaligned mapped ones
        if (!ar_dec[8]) begin
            rd_val = 8'h00;
        end

        s_d = s_q;
        s_d.wdt_rst = 1'b0;

        // write address and data are taken in either order
        if (i_awvalid && o_awready) begin
            s_d.aw_hold = 1'b1;
            s_d.aw_idx = aw_dec[7:0];
            s_d.aw_hit = aw_dec[8];
        end
        if (i_wvalid && o_wready) begin
            s_d.w_hold = 1'b1;
            s_d.w_nib = i_wdata[3:0];
            s_d.w_lane = i_wstrb[0];
        end
        if (wr_go) begin
            s_d.aw_hold = 1'b0;
            s_d.w_hold = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = s_q.aw_hit ? `TCU_RESP_OKAY : `TCU_RESP_SLVERR;
        end
        if (s_q.bvalid && i_bready) begin
            s_d.bvalid = 1'b0;
        end

        // register effects of a write; lane 0 carries every field
        if (wr_go && s_q.aw_hit && s_q.w_lane) begin
            case (s_q.aw_idx)
                `TCU_IDX_PORT_MODE: s_d.port_mode = s_q.w_nib;
                `TCU_IDX_TIMER_MODE: s_d.timer_mode = s_q.w_nib;
                `TCU_IDX_LOW_NIB: s_d.wr_low = s_q.w_nib;
                `TCU_IDX_HIGH_NIB: s_d.wr_high = s_q.w_nib;
                `TCU_IDX_WATCHDOG_ENABLE_FLAG: begin
                    // set-only: a zero write leaves the flag alone
                    s_d.watchdog_enable_flag = s_q.watchdog_enable_flag | s_q.w_nib[`TCU_WATCHDOG_ENABLE_FLAG_BIT];
                end
                `TCU_IDX_CTRL: begin
                    s_d.irq_mask = s_q.w_nib[`TCU_MASK_BIT];
                    s_d.sys_div = s_q.w_nib[`TCU_DIV_MSB:`TCU_DIV_LSB];
                end
                default: begin
                    s_d.sys_div = s_q.sys_div;
                end
            endcase
        end

        // read side; high read latches the live low nibble
        if (ar_go) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_val;
            s_d.rresp = ar_dec[8] ? `TCU_RESP_OKAY : `TCU_RESP_SLVERR;
        end
        if (rd_hi) begin
            s_d.rd_low = s_q.cnt[3:0];
        end
        if (s_q.rvalid && i_rready) begin
            s_d.rvalid = 1'b0;
        end

        // counter: load beats tick; overflow wraps or reloads
        if (wr_hi) begin
            s_d.cnt = {s_q.w_nib, s_q.wr_low};
        end else if (ovf) begin
            if (s_q.timer_mode[`TCU_FSEL_BIT]) begin
                s_d.cnt = {s_q.wr_high, s_q.wr_low};
            end else begin
                s_d.cnt = `TCU_CNT_RST;
            end
        end else if (tick) begin
            s_d.cnt = s_q.cnt + `TCU_CNT_ONE;
        end

        // flag: set wins over a software clear in the same cycle
        if (wr_go && s_q.aw_hit && s_q.w_lane
            && (s_q.aw_idx == `TCU_IDX_STATUS)
            && !s_q.w_nib[`TCU_FLAG_BIT]) begin
            s_d.ovf_flag = 1'b0;
        end
        if (ovf) begin
            s_d.ovf_flag = 1'b1;
            s_d.tout = !s_q.tout;
            s_d.wdt_rst = s_q.watchdog_enable_flag;
        end

        // stop entry initialises the timer state
        if (i_stop_enter) begin
            s_d.timer_mode = `TCU_MODE_RST;
            s_d.cnt = `TCU_CNT_RST;
            s_d.wr_low = `TCU_NIB_RST;
            s_d.watchdog_enable_flag = 1'b0;
            s_d.rd_low = s_q.rd_low;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s_q <= '0;
            s_q.irq_mask <= `TCU_MASK_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_bvalid = s_q.bvalid;
    assign o_bresp = s_q.bresp;
    assign o_rvalid = s_q.rvalid;
    assign o_rresp = s_q.rresp;
    assign o_rdata = {24'h00_0000, s_q.rdata};
    // pwm waveform is not built; the pin shows an overflow toggle
    assign o_pin_out = s_q.port_mode[`TCU_PINF_BIT] ? s_q.tout : i_port_out;
    assign o_pin_oe = s_q.port_mode[`TCU_PINF_BIT] | i_port_oe;
    assign o_ovf_irq = s_q.ovf_flag && !s_q.irq_mask;
    assign o_wdt_reset = s_q.wdt_rst;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    chk_stop_init: assert property (
        i_stop_enter |=> (s_q.cnt == `TCU_CNT_RST)
            && (s_q.timer_mode == `TCU_MODE_RST)
            && (s_q.wr_low == `TCU_NIB_RST) && !s_q.watchdog_enable_flag)
        else $error("stop entry did not initialise timer");

    chk_free_wrap: assert property (
        ovf && !s_q.timer_mode[`TCU_FSEL_BIT] |=> s_q.cnt == `TCU_CNT_RST)
        else $error("free-running overflow did not clear counter");

    chk_reload_val: assert property (
        ovf && s_q.timer_mode[`TCU_FSEL_BIT]
        |=> s_q.cnt == {$past(s_q.wr_high), $past(s_q.wr_low)})
        else $error("reload overflow loaded wrong value");

    chk_count_step: assert property (
        tick && !wr_hi && !i_stop_enter && s_q.cnt != `TCU_CNT_MAX
        |=> s_q.cnt == $past(s_q.cnt) + `TCU_CNT_ONE)
        else $error("counter did not step on tick");

    chk_count_hold: assert property (
        !tick && !wr_hi && !i_stop_enter |=> $stable(s_q.cnt))
        else $error("counter moved without tick or load");

    chk_high_load: assert property (
        wr_hi && !i_stop_enter
        |=> s_q.cnt == {$past(s_q.w_nib), $past(s_q.wr_low)})
        else $error("high nibble write did not load counter");

    chk_flag_wdog: assert property (
        ovf |=> s_q.ovf_flag && (o_wdt_reset == $past(s_q.watchdog_enable_flag)))
        else $error("overflow flag or watchdog reset wrong");

    chk_watchdog_enable_flag_sticky: assert property (
        s_q.watchdog_enable_flag && !i_stop_enter |=> s_q.watchdog_enable_flag)
        else $error("watchdog flag cleared by software");

    chk_irq_gate: assert property (
        ovf && !s_q.irq_mask && !(wr_go && s_q.aw_idx == `TCU_IDX_CTRL)
        |=> o_ovf_irq)
        else $error("unmasked overflow raised no interrupt");

    chk_low_latch: assert property (
        rd_hi && !i_stop_enter |=> s_q.rd_low == $past(s_q.cnt[3:0]))
        else $error("high read did not latch low nibble");

    chk_low_read: assert property (
        ar_go && (ar_dec == {1'b1, `TCU_IDX_LOW_NIB})
        |=> o_rdata[3:0] == $past(s_q.rd_low))
        else $error("low read did not return latched nibble");

    chk_pin_route: assert property (
        !s_q.port_mode[`TCU_PINF_BIT] |-> o_pin_out == i_port_out)
        else $error("port pin not routed to port logic");

    chk_pin_timer: assert property (
        s_q.port_mode[`TCU_PINF_BIT]
        |-> (o_pin_out == s_q.tout) && o_pin_oe)
        else $error("timer output not routed to shared pin");

    chk_wdt_pulse: assert property (
        o_wdt_reset |=> !o_wdt_reset)
        else $error("watchdog reset wider than one cycle");

    chk_low_store: assert property (
        wr_lo && !i_stop_enter |=> s_q.wr_low == $past(s_q.w_nib))
        else $error("low nibble write not stored");

    chk_mode_write: assert property (
        wr_go && s_q.aw_hit && s_q.w_lane && !i_stop_enter
            && (s_q.aw_idx == `TCU_IDX_TIMER_MODE)
        |=> s_q.timer_mode == $past(s_q.w_nib))
        else $error("timer mode write not applied");

    chk_flag_hold: assert property (
        s_q.ovf_flag && !(wr_go && s_q.aw_hit && s_q.w_lane
            && (s_q.aw_idx == `TCU_IDX_STATUS))
        |=> s_q.ovf_flag)
        else $error("overflow flag cleared without software");

    chk_mask_gate: assert property (
        s_q.irq_mask |-> !o_ovf_irq)
        else $error("masked overflow raised an interrupt");

    chk_tick_single: assert property (
        tick |=> !tick)
        else $error("prescaler tick wider than one cycle");

    chk_write_err: assert property (
        wr_go && !s_q.aw_hit |=> o_bresp == `TCU_RESP_SLVERR)
        else $error("refused write answered without error");

endmodule : tcu_timer
`default_nettype wire
